// File: design/ccp_nco.sv
// Feedback NCO dividing VCO ticks by the mixed number R + N/M
module ccp_nco (
  input wire logic core_clk,
  input wire logic rst_n,
  ccp_pll_if.nco pll
);
  logic [3:0] cnt_ff;
  logic [15:0] acc_ff;
  logic extend_ff;
  logic use_frac;
  logic [16:0] sum;
  logic [16:0] rem;
  logic carry;
  logic [4:0] period_m1;
  logic wrap;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // M of zero would divide by nothing, so it falls back to integer
  assign use_frac = pll.frac && (pll.m != 16'h0000);
  assign sum = {1'b0, acc_ff} + {1'b0, pll.n};
  assign carry = use_frac && (sum >= {1'b0, pll.m});
  assign rem = carry ? sum - {1'b0, pll.m} : sum;
  assign period_m1 = {1'b0, pll.r} - 5'd1 + {4'h0, extend_ff};
  assign wrap = {1'b0, cnt_ff} >= period_m1;
  assign pll.fb_tick = pll.vco_tick && wrap;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      acc_ff <= '0;
    end else if (pll.vco_tick) begin
      if (wrap) begin
        cnt_ff <= '0;
        // Residue from an older, larger M is dropped, not paid off over many periods
        acc_ff <= (!use_frac || rem >= {1'b0, pll.m}) ? 16'h0000 : rem[15:0];
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // Integer mode drops a pending stretch at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extend_ff <= 1'b0;
    end else if (pll.vco_tick && wrap) begin
      extend_ff <= carry;
    end else if (!use_frac) begin
      extend_ff <= 1'b0;
    end
  end

  a_integer_plain: assert property (!use_frac |=> !extend_ff)
    else $error("integer mode stretched a feedback period");
endmodule

// File: design/ccp_tick_div.sv
// Programmable divider of a one-cycle tick stream
module ccp_tick_div #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] div,
  input wire logic tick_in,
  output logic tick_out
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] div_m1;

  if (W < 1 || W > 8) begin : g_bad_w
    $error("ccp_tick_div width out of range");
  end

  assign div_m1 = div - 1'b1;
  // Compare with >= so a shrinking divisor never strands the counter
  assign tick_out = tick_in && (cnt_ff >= div_m1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (tick_in) begin
      cnt_ff <= (cnt_ff >= div_m1) ? '0 : cnt_ff + 1'b1;
    end
  end
endmodule

// File: design/ccp_top.sv
// Clock source, core divider, clock output, supply level and synthesizer control
// Summary of operation
// - Source bit 3: 0 takes master clock pin, 1 takes synthesizer output.
// - Bits 6:5 pick clock output rate 32, 64, 128 or 256 times fs.
// - Bit 4 enables clock output pin; default disabled.
// - Bits 2:1 declare input as 256..1024 fs; divide by 1..4 to 256 fs.
// - Synthesizer output is always 1024 fs, so core divides it by four; here the core divides by bits 2:1 plus one, four only for code 11.
// - Bit 0 gates the core clock; default off.
// - Bits 2:1 of supply register set core supply level; reset is 1.4 V.
// - Denominator M is bits 47:40 joined with bits 39:32.
// - Numerator N is bits 31:24 joined with bits 23:16.
// - Bits 10:9 divide the reference by X plus one before the synthesizer.
// - Bit 8 chooses fractional or integer-N operation.
// - Feedback divides VCO by R plus N over M in fractional mode.
// - Bit 1 of synthesizer register is read-only lock status.
// - Lock status stays set once set.
// - Bit 0 of synthesizer register enables the synthesizer.
//
// Chosen here: the strobed register port.
module ccp_top
  import ccp_pkg::*;
#(
  parameter int LOCK_WIN = ccp_pkg::LOCK_WIN_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ccp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ccp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ccp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic master_clock_in_pin,
  input wire logic pll_vco_pin,
  output logic pll_ref_tick,
  output logic core_tick,
  output logic core_clk_running,
  output logic clock_out_pin,
  output logic pll_enable,
  output logic pll_locked,
  output logic [1:0] core_supply_output_level
);
  import ccp_pkg::*;

  logic [7:0] clk_ctrl_ff;
  logic [7:0] supply_ff;
  logic [47:0] pll_act_ff;
  logic [47:0] stage_ff;
  logic [2:0] burst_idx_ff;
  logic [7:0] rdata_ff;
  logic act_src_ff;
  logic [1:0] act_div_ff;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] lvl_ff;
  logic [7:0] win_cnt_ff;
  logic [8:0] fb_cnt_ff;
  logic lock_ff;
  logic clk_out_ff;
  logic [1:0] rise;
  logic mclk_rise;
  logic vco_rise;
  logic src_tick;
  logic div_tick;
  logic out_tick;
  logic [2:0] pll_idx;
  logic pll_hit;
  logic burst_ok;
  logic apply;
  logic [47:0] last_stage;

  ccp_pll_if pll_bus ();

  if (LOCK_WIN < 4 || LOCK_WIN > 255) begin : g_bad_win
    $error("LOCK_WIN must be 4 to 255");
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [2:0] pll_index(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - ADDR_PLL_BASE;
    pll_index = (off < 16'(PLL_BYTES)) ? off[2:0] : 3'h7;
  endfunction

  function automatic logic [5:0] byte_shift(input logic [2:0] idx);
    byte_shift = 6'(PLL_W - 8 - 8 * int'(idx));
  endfunction

  function automatic logic [47:0] put_byte(input logic [47:0] v, input logic [2:0] idx, input logic [7:0] b);
    put_byte = (v & ~(48'h0000_0000_00FF << byte_shift(idx))) | (48'(b) << byte_shift(idx));
  endfunction

  function automatic logic [7:0] get_byte(input logic [47:0] v, input logic [2:0] idx);
    get_byte = 8'(v >> byte_shift(idx));
  endfunction

  // Pin sampling; core_clk must outrun the pins by well over four to one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= {pll_vco_pin, master_clock_in_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
    end
  end

  assign rise = ~lvl_ff & s2_ff & s3_ff;
  assign mclk_rise = rise[0];
  assign vco_rise = rise[1];

  // Register decode
  assign pll_idx = pll_index(reg_addr);
  assign pll_hit = pll_idx < 3'(PLL_BYTES);
  assign burst_ok = reg_wr && pll_hit && (pll_idx == 3'h0 || pll_idx == burst_idx_ff);
  assign apply = burst_ok && (pll_idx == 3'(PLL_BYTES - 1));
  assign last_stage = put_byte(stage_ff, pll_idx, reg_wdata);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctrl_ff <= CC_RST;
    end else if (reg_wr && reg_addr == ADDR_CLK_CTRL) begin
      clk_ctrl_ff <= reg_wdata & CC_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_ff <= SUP_RST;
    end else if (reg_wr && reg_addr == ADDR_SUPPLY) begin
      supply_ff <= reg_wdata & SUP_MASK;
    end
  end

  // Any other access between the bytes abandons the burst
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_ff <= PL_RST;
      burst_idx_ff <= '0;
    end else if (burst_ok) begin
      stage_ff <= last_stage;
      burst_idx_ff <= apply ? 3'h0 : pll_idx + 3'h1;
    end else if (reg_wr || reg_rd) begin
      burst_idx_ff <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_act_ff <= PL_RST;
    end else if (apply) begin
      pll_act_ff <= last_stage & PL_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (!reg_rd) begin
      rdata_ff <= '0;
    end else if (reg_addr == ADDR_CLK_CTRL) begin
      rdata_ff <= clk_ctrl_ff;
    end else if (reg_addr == ADDR_SUPPLY) begin
      rdata_ff <= supply_ff;
    end else if (pll_hit) begin
      rdata_ff <= get_byte(pll_act_ff | (48'(lock_ff) << PL_LOCK), pll_idx);
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;

  // Synthesizer settings to the feedback NCO
  assign pll_bus.m = pll_act_ff[PL_M_LO +: 16];
  assign pll_bus.n = pll_act_ff[PL_N_LO +: 16];
  assign pll_bus.r = pll_act_ff[PL_R_LO +: 4];
  assign pll_bus.frac = pll_act_ff[PL_TYPE];
  assign pll_bus.vco_tick = vco_rise && pll_act_ff[PL_EN];

  ccp_nco u_nco (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pll(pll_bus)
  );

  ccp_tick_div #(.W(3)) u_ref_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div({1'b0, pll_act_ff[PL_X_LO +: 2]} + 3'h1),
    .tick_in(mclk_rise && pll_act_ff[PL_EN]),
    .tick_out(pll_ref_tick)
  );

  // Lock: feedback count within one of reference count over a window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_ff <= '0;
      fb_cnt_ff <= '0;
      lock_ff <= 1'b0;
    end else if (!pll_act_ff[PL_EN] || apply) begin
      win_cnt_ff <= '0;
      fb_cnt_ff <= '0;
    end else if (pll_ref_tick && win_cnt_ff == 8'(LOCK_WIN - 1)) begin
      win_cnt_ff <= '0;
      fb_cnt_ff <= '0;
      if (fb_cnt_ff + 9'(pll_bus.fb_tick) + 9'd1 >= 9'(LOCK_WIN) && fb_cnt_ff <= 9'(LOCK_WIN)) begin
        lock_ff <= 1'b1;
      end
    end else begin
      if (pll_ref_tick) begin
        win_cnt_ff <= win_cnt_ff + 8'd1;
      end
      if (pll_bus.fb_tick && fb_cnt_ff != 9'h1FF) begin
        fb_cnt_ff <= fb_cnt_ff + 9'd1;
      end
    end
  end

  // Source and divider copies only follow while the core is stopped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_src_ff <= 1'b0;
      act_div_ff <= '0;
    end else if (!clk_ctrl_ff[CC_CORE_EN]) begin
      act_src_ff <= clk_ctrl_ff[CC_SRC_SEL];
      act_div_ff <= clk_ctrl_ff[CC_MCLK_LO +: 2];
    end
  end

  // 1024 fs from the synthesizer leaves code 11 and a divide by four
  assign src_tick = act_src_ff ? vco_rise : mclk_rise;

  ccp_tick_div #(.W(3)) u_core_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div({1'b0, act_div_ff} + 3'h1),
    .tick_in(src_tick),
    .tick_out(div_tick)
  );

  assign core_tick = div_tick && clk_ctrl_ff[CC_CORE_EN];
  assign core_clk_running = clk_ctrl_ff[CC_CORE_EN];

  ccp_tick_div #(.W(4)) u_out_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div(OUT_DIV_32FS >> clk_ctrl_ff[CC_OUT_LO +: 2]),
    .tick_in(core_tick),
    .tick_out(out_tick)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_ff <= 1'b0;
    end else begin
      clk_out_ff <= out_tick && clk_ctrl_ff[CC_OUT_EN];
    end
  end

  assign clock_out_pin = clk_out_ff;
  assign pll_enable = pll_act_ff[PL_EN];
  assign pll_locked = lock_ff;
  assign core_supply_output_level = supply_ff[SUP_LVL_LO +: 2];

  a_core_gate_off: assert property (!clk_ctrl_ff[CC_CORE_EN] |-> !core_tick)
    else $error("core tick while core clock disabled");
  a_src_frozen_run: assert property (clk_ctrl_ff[CC_CORE_EN] |=> $stable(act_src_ff) && $stable(act_div_ff))
    else $error("clock source changed while core running");
  a_out_pin_off: assert property (!clk_ctrl_ff[CC_OUT_EN] |=> !clock_out_pin)
    else $error("clock output active while disabled");
  a_out_full_rate: assert property (clk_ctrl_ff[CC_OUT_LO +: 2] == 2'b11 && clk_ctrl_ff[CC_OUT_EN] && core_tick
    |=> clock_out_pin)
    else $error("256 fs output missed a core tick");
  a_lock_sticky: assert property (pll_locked |=> pll_locked)
    else $error("lock status dropped");
  a_lock_needs_en: assert property ($rose(lock_ff) |-> $past(pll_act_ff[PL_EN]))
    else $error("lock set while synthesizer disabled");
  a_partial_hold: assert property (reg_wr && pll_hit && !apply |=> $stable(pll_act_ff))
    else $error("partial burst reached synthesizer settings");
  a_burst_six: assert property (apply |-> $past(reg_wr) && $past(reg_wr, 2) && $past(reg_wr, 3)
    && $past(reg_wr, 4) && $past(reg_wr, 5))
    else $error("settings applied without six back to back writes");
  a_lock_read: assert property (reg_rd && pll_idx == 3'h5 |=> reg_rdata[PL_LOCK] == $past(lock_ff))
    else $error("lock bit read wrong");
  a_supply_write: assert property (reg_wr && reg_addr == ADDR_SUPPLY
    |=> core_supply_output_level == $past(reg_wdata[2:1]))
    else $error("supply level not updated");
  a_core_src_pll: assert property (act_src_ff && clk_ctrl_ff[CC_CORE_EN] && core_tick |-> vco_rise)
    else $error("core tick not from synthesizer");

  c_lock_set: cover property ($rose(pll_locked));
  c_burst_apply: cover property (apply);
  c_core_tick: cover property (core_tick && act_src_ff);
  c_clock_out: cover property (clock_out_pin);
endmodule

// File: include/ccp_pkg.sv
// Constants for the codec clock and synthesizer control block
package ccp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] ADDR_CLK_CTRL = 16'h4000;
  localparam logic [15:0] ADDR_SUPPLY = 16'h4001;
  localparam logic [15:0] ADDR_PLL_BASE = 16'h4002;
  localparam int PLL_BYTES = 6;
  localparam int PLL_W = 48;
  localparam int CC_CORE_EN = 0;
  localparam int CC_MCLK_LO = 1;
  localparam int CC_SRC_SEL = 3;
  localparam int CC_OUT_EN = 4;
  localparam int CC_OUT_LO = 5;
  localparam logic [7:0] CC_RST = 8'h00;
  localparam logic [7:0] CC_MASK = 8'h7F;
  localparam int SUP_LVL_LO = 1;
  localparam logic [7:0] SUP_RST = 8'h02;
  localparam logic [7:0] SUP_MASK = 8'h06;
  localparam int PL_EN = 0;
  localparam int PL_LOCK = 1;
  localparam int PL_TYPE = 8;
  localparam int PL_X_LO = 9;
  localparam int PL_R_LO = 11;
  localparam int PL_N_LO = 16;
  localparam int PL_M_LO = 32;
  localparam logic [47:0] PL_RST = 48'h0753_0287_1901;
  localparam logic [47:0] PL_MASK = 48'hFFFF_FFFF_7F01;
  localparam int LOCK_WIN_DEF = 32;
  localparam logic [1:0] MCLK_1024FS = 2'b11;
  localparam logic [3:0] OUT_DIV_32FS = 4'h8;
endpackage

// File: include/ccp_pll_if.sv
// Synthesizer settings and feedback ticks between controller and NCO
interface ccp_pll_if;
  logic [15:0] m;
  logic [15:0] n;
  logic [3:0] r;
  logic frac;
  logic vco_tick;
  logic fb_tick;
  modport ctrl (output m, output n, output r, output frac, output vco_tick, input fb_tick);
  modport nco (input m, input n, input r, input frac, input vco_tick, output fb_tick);
endinterface

// File: test/ccp_clk_src.sv
// Master clock source and synthesizer oscillator seen by the clock control block
module ccp_clk_src #(
  parameter int MCLK_HALF = 600,
  parameter int VCO_HALF = 300
) (
  output logic master_clock_in_pin,
  output logic pll_vco_pin,
  input wire logic pll_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Free running at one fixed rate whatever the bench declares in the divider field
  initial begin
    master_clock_in_pin = 1'b0;
    #37;
    forever #MCLK_HALF master_clock_in_pin = ~master_clock_in_pin;
  end
  // Twice the reference rate; stands still at 0 while the synthesizer is off
  initial begin
    pll_vco_pin = 1'b0;
    #53;
    forever begin
      #VCO_HALF;
      pll_vco_pin = pll_enable ? ~pll_vco_pin : 1'b0;
    end
  end
endmodule

// File: test/ccp_top_bench.sv
// Register and clock tests of the clock control block
module ccp_top_bench import ccp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic mclk;
  logic vco;
  logic pll_ref_tick;
  logic core_tick;
  logic core_clk_running;
  logic clock_out_pin;
  logic pll_enable;
  logic pll_locked;
  logic [1:0] core_supply_output_level;
  logic clr = 1'b0;
  logic mck_q = 1'b0;
  logic vco_q = 1'b0;
  int n_core, n_out, n_ref, n_mck, n_vco;
  int fail_count = 0;
  int cmp_count = 0;

  always #50 core_clk = ~core_clk;

  // Window wide enough that a 20 percent rate error can never pass the one-count slack
  ccp_top #(.LOCK_WIN(16)) u_ccp_top (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_clock_in_pin(mclk),
    .pll_vco_pin(vco), .pll_ref_tick(pll_ref_tick), .core_tick(core_tick),
    .core_clk_running(core_clk_running), .clock_out_pin(clock_out_pin), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .core_supply_output_level(core_supply_output_level)
  );
  ccp_clk_src u_ccp_clk_src (.master_clock_in_pin(mclk), .pll_vco_pin(vco), .pll_enable(pll_enable));

  // Event counters; pin edges seen by plain sampling, so counts carry one unit of slack
  always @(posedge core_clk) begin
    mck_q <= mclk;
    vco_q <= vco;
    if (clr) begin
      n_core <= 0; n_out <= 0; n_ref <= 0; n_mck <= 0; n_vco <= 0;
    end else begin
      n_core <= n_core + int'(core_tick);
      n_out <= n_out + int'(clock_out_pin);
      n_ref <= n_ref + int'(pll_ref_tick);
      n_mck <= n_mck + int'(mclk & ~mck_q);
      n_vco <= n_vco + int'(vco & ~vco_q);
    end
  end

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input int tol);
    cmp_count++;
    if (got > exp + tol || got < exp - tol) begin
      fail_count++;
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #10;
    check8(reg_rdata, exp);
  endtask

  // Consecutive bytes, highest first, strobe held for the whole run
  task automatic burst(input logic [47:0] v, input int cnt);
    @(posedge core_clk);
    for (int i = 0; i < cnt; i++) begin
      reg_wr <= 1'b1;
      reg_addr <= ADDR_PLL_BASE + 16'(i);
      reg_wdata <= v[47-8*i -: 8];
      @(posedge core_clk);
    end
    reg_wr <= 1'b0;
  endtask

  task automatic win(input int cyc);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge core_clk);
    #10;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #10;
    check8({7'h00, pll_enable}, 8'h01);
    check8({6'h00, core_supply_output_level}, 8'h01);
    rdc(ADDR_CLK_CTRL, CC_RST);
    rdc(ADDR_SUPPLY, SUP_RST);
    rdc(ADDR_PLL_BASE, PL_RST[47:40]);
    rdc(ADDR_PLL_BASE + 16'h0005, 8'h01);
    win(300);
    chk_cnt(n_core, 0, 0);
    chk_cnt(n_out, 0, 0);
    wr(ADDR_SUPPLY, 8'hFF);
    rdc(ADDR_SUPPLY, 8'h06);
    check8({6'h00, core_supply_output_level}, 8'h03);
    wr(16'h4010, 8'hFF);
    rdc(16'h4010, 8'h00);
    // Fractional R=2, N/M=1/2: divisor 2.5 is too slow to lock; integer-only logic would lock
    burst(48'h0002_0001_1101, 6);
    rdc(ADDR_PLL_BASE + 16'h0001, 8'h02);
    rdc(ADDR_PLL_BASE + 16'h0003, 8'h01);
    rdc(ADDR_PLL_BASE + 16'h0004, 8'h11);
    repeat (400) @(posedge core_clk);
    check8({7'h00, pll_locked}, 8'h00);
    burst(48'hFFFF_FFFF_FFFF, 3);
    rdc(ADDR_PLL_BASE, 8'h00);
    // Integer R=2 against a VCO at twice the reference locks only without input division
    for (int x = 0; x < 4; x++) begin
      burst({32'h0000_0000, 1'b0, 4'd2, 2'(x), 9'h001}, 6);
      win(1200);
      chk_cnt(n_ref, n_mck / (x + 1), 1);
    end
    check8({7'h00, pll_locked}, 8'h01);
    rdc(ADDR_PLL_BASE + 16'h0005, 8'h03);
    burst(48'h0000_0000_1000, 6);
    #10;
    check8({pll_enable, pll_locked}, 8'h01);
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CLK_CTRL, {5'h00, 2'(d), 1'b0});
      wr(ADDR_CLK_CTRL, {5'h00, 2'(d), 1'b1});
      win(1200);
      chk_cnt(n_core, n_mck / (d + 1), 1);
      wr(ADDR_CLK_CTRL, 8'h00);
    end
    // Divider change while running must wait for the gate to close
    wr(ADDR_CLK_CTRL, 8'h01);
    wr(ADDR_CLK_CTRL, 8'h07);
    win(1200);
    chk_cnt(n_core, n_mck, 1);
    rdc(ADDR_CLK_CTRL, 8'h07);
    wr(ADDR_CLK_CTRL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLK_CTRL, {1'b0, 2'(c), 1'b1, 4'h1});
      win(1200);
      chk_cnt(n_out, n_core / (8 >> c), 1);
    end
    wr(ADDR_CLK_CTRL, 8'h00);
    burst(48'h0000_0000_1001, 6);
    wr(ADDR_CLK_CTRL, 8'h0E);
    wr(ADDR_CLK_CTRL, 8'h0F);
    win(1200);
    chk_cnt(n_core, n_vco / 4, 1);
    check8({7'h00, core_clk_running}, 8'h01);
    close_out();
  end
endmodule
